//--- common/fsl_pkg.sv
// constants and types for the flash self-programming and lock control block
// ============================================================
// Functional notes
// - store-enable alone: next store writes register pair into buffer word at pointer, bit0 ignored
// - store-enable clears on store completion or after four idle cycles
// - during page erase or write store-enable stays set until operation done
// - only five low-bit patterns accepted; other writes to control only clear the blocked-store status bit
// - extended-row enable bit 6 activates extended extra-row addressing via row select
// - row select bits 5:4 used only in extended mode; 0 signature, 1-3 user rows
// - signature row stays reachable when extended addressing is off
// - six lock bits, 1 unprogrammed; return to 1 only by chip erase
// - general lock mode 2 refuses external programming and fuse changes
// - general lock mode 3 refuses external programming, verify, boot-lock and fuse changes
// - app-lock mode 2 blocks stores to application section
// - app-lock mode 3 blocks app stores, boot loads of app, masks interrupts
// - app-lock mode 4 only read restriction and interrupt masking
// - boot-lock mode 2 blocks stores to boot section
// - boot-lock mode 3 blocks boot stores, app loads of boot, masks interrupts
// - boot-lock mode 4 only read restriction and interrupt masking
// - three fuse bytes; programmed reads zero, unprogrammed reads one
// - extended fuse bits 2:0 default 110, bit 3 reserved one, 7:4 read one
// - high fuse defaults: debug and watchdog unprogrammed, test port and serial programmed
// - store-enable with page write or erase: next store acts on pointer page
// - store-enable with lock set: next store sets app and boot locks from low register bits 5:2
// - load within three cycles after lock-set returns lock bits or fuse by pointer bit 0
package fsl_pkg;
    localparam logic [7:0] ADDR_SELFPROG_CTRL = 8'h57;
    localparam logic [7:0] ADDR_EXTRA_ROW     = 8'h75;
    localparam logic [7:0] ADDR_LOCK_BITS     = 8'h80;
    localparam logic [7:0] ADDR_FUSE_EXT      = 8'h81;
    localparam logic [7:0] ADDR_FUSE_HIGH     = 8'h82;
    localparam logic [7:0] ADDR_FUSE_LOW      = 8'h83;
    localparam logic [7:0] ADDR_ACCESS_STAT   = 8'h84;
    localparam logic [7:0] ADDR_CHIP_ERASE    = 8'h85;
    localparam logic [7:0] CHIP_ERASE_KEY     = 8'hA5;
    localparam logic [4:0] CMD_FILL           = 5'h01;
    localparam logic [4:0] CMD_ERASE          = 5'h03;
    localparam logic [4:0] CMD_WRITE          = 5'h05;
    localparam logic [4:0] CMD_LOCKSET        = 5'h09;
    localparam logic [4:0] CMD_RWWRE          = 5'h11;
    localparam int         STORE_WIN_CYC      = 4;
    localparam int         LOAD_WIN_CYC       = 3;
    localparam logic [2:0] STORE_WIN          = 3'h4;
    localparam logic [2:0] LOAD_WIN           = 3'h3;
    localparam logic [7:0] EXTRA_ROW_RESET    = 8'h0A;
    localparam logic [7:0] LOCK_RESET         = 8'hFF;
    localparam logic [7:0] FUSE_EXT_RESET     = 8'hFE;
    localparam logic [7:0] FUSE_EXT_FIXED     = 8'hF8;
    localparam logic [7:0] FUSE_HIGH_RESET    = 8'h99;
    localparam logic [7:0] FUSE_LOW_RESET     = 8'h62;
    localparam int         ROW_EN_BIT         = 6;
    localparam int         ROW_SEL_LO         = 4;
    localparam int         PAGE_LSB           = 8;
    localparam int         WORD_BITS          = 7;
    localparam int         ADDR_BITS          = 18;
    localparam int         LOCK_GEN_LO        = 0;
    localparam int         LOCK_APP_LO        = 2;
    localparam int         LOCK_BOOT_LO       = 4;
    typedef enum logic [1:0] {FSL_LOCK_NONE, FSL_LOCK_WRITE, FSL_LOCK_ALL, FSL_LOCK_READ} fsl_lock_t;
    typedef enum logic [1:0] {FSL_ROW_SIG, FSL_ROW_USER1, FSL_ROW_USER2, FSL_ROW_USER3} fsl_row_t;
endpackage

//--- src/fsl_ctrl.sv
// self-programming command control, extra-row mode and lock/fuse protection
`timescale 1ns/1ns
`default_nettype none
module fsl_ctrl (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [7:0]       reg_rdata,
    input  wire logic        store_instr,
    input  wire logic        load_instr,
    input  wire logic [17:0] ptr,
    input  wire logic [15:0] reg_pair,
    input  wire logic        exec_in_boot,
    input  wire logic        vectors_in_boot,
    input  wire logic [17:0] boot_start,
    input  wire logic        nvm_done,
    input  wire logic        ext_prog_mode,
    output logic             buf_we,
    output logic [6:0]       buf_word,
    output logic [15:0]      buf_data,
    output logic             page_erase,
    output logic             page_write,
    output logic [9:0]       page_addr,
    output logic             rww_reenable,
    output logic             load_special,
    output logic [7:0]       load_data,
    output logic             load_blocked,
    output logic             load_sig_space,
    output logic [1:0]       load_row,
    output logic             irq_mask,
    output logic             ext_prog_refused,
    output logic             ext_verify_refused,
    output logic             ext_lock_refused
);
    // ============================================================
    // state
    logic [4:0] cmd_reg;
    logic [4:0] cmd_next;
    logic [2:0] win_reg;
    logic [2:0] win_next;
    logic       busy_reg;
    logic       busy_next;
    logic       sig_rd_reg;
    logic [7:0] row_ctrl_reg;
    logic [7:0] lock_reg;
    logic [7:0] fuse_ext_reg;
    logic [7:0] fuse_high_reg;
    logic [7:0] fuse_low_reg;
    logic       blocked_store_reg;

    // ============================================================
    // decode
    wire        wr_ctrl     = reg_wr && (reg_addr == fsl_pkg::ADDR_SELFPROG_CTRL);
    wire        wr_row      = reg_wr && (reg_addr == fsl_pkg::ADDR_EXTRA_ROW);
    wire        wr_erase    = reg_wr && (reg_addr == fsl_pkg::ADDR_CHIP_ERASE) &&
                              (reg_wdata == fsl_pkg::CHIP_ERASE_KEY);
    wire        wr_lock     = reg_wr && (reg_addr == fsl_pkg::ADDR_LOCK_BITS) && ext_prog_mode;
    wire [4:0]  wr_cmd      = reg_wdata[4:0];
    wire        cmd_legal   = (wr_cmd == fsl_pkg::CMD_FILL) || (wr_cmd == fsl_pkg::CMD_ERASE) ||
                              (wr_cmd == fsl_pkg::CMD_WRITE) || (wr_cmd == fsl_pkg::CMD_LOCKSET) ||
                              (wr_cmd == fsl_pkg::CMD_RWWRE);
    wire        accept_cmd  = wr_ctrl && cmd_legal && !busy_reg;
    wire        store_armed = (cmd_reg != 5'h00) && !busy_reg;
    wire        store_go    = store_instr && store_armed;
    wire        in_boot_tgt = (ptr >= boot_start);

    fsl_pkg::fsl_lock_t app_mode;
    fsl_pkg::fsl_lock_t boot_mode;
    logic app_wblk;
    logic app_rblk;
    logic boot_wblk;
    logic boot_rblk;

    fsl_lock_decode u_app (
        .lock_pair   (lock_reg[fsl_pkg::LOCK_APP_LO +: 2]),
        .mode        (app_mode),
        .block_write (app_wblk),
        .block_read  (app_rblk)
    );
    fsl_lock_decode u_boot (
        .lock_pair   (lock_reg[fsl_pkg::LOCK_BOOT_LO +: 2]),
        .mode        (boot_mode),
        .block_write (boot_wblk),
        .block_read  (boot_rblk)
    );

    // current lock values on every access
    wire        tgt_wblk    = in_boot_tgt ? boot_wblk : app_wblk;
    wire        store_mem   = (cmd_reg == fsl_pkg::CMD_ERASE) || (cmd_reg == fsl_pkg::CMD_WRITE);
    wire        store_block = store_go && store_mem && tgt_wblk;
    wire        rd_blk      = (exec_in_boot && !in_boot_tgt && app_rblk) ||
                              (!exec_in_boot && in_boot_tgt && boot_rblk);
    wire        load_lock   = load_instr && (cmd_reg == fsl_pkg::CMD_LOCKSET) &&
                              (win_reg > (fsl_pkg::STORE_WIN - fsl_pkg::LOAD_WIN));
    wire        load_sig    = load_instr && sig_rd_reg && (win_reg != 3'h0);
    wire        row_en      = row_ctrl_reg[fsl_pkg::ROW_EN_BIT];
    wire [1:0]  row_sel     = row_en ? row_ctrl_reg[fsl_pkg::ROW_SEL_LO +: 2] : 2'h0;
    wire [1:0]  gen_lock    = lock_reg[fsl_pkg::LOCK_GEN_LO +: 2];
    wire        irq_m       = (exec_in_boot && !vectors_in_boot && boot_rblk) ||
                              (!exec_in_boot && vectors_in_boot && app_rblk);
    wire [7:0]  lock_new    = lock_reg & {2'b11, reg_pair[5:2], 2'b11};
    wire [7:0]  lock_ext    = lock_reg & {2'b11, ((gen_lock == 2'b00) ? 4'hF : reg_wdata[5:2]), reg_wdata[1:0]};
    wire [7:0]  fuse_sel    = ptr[0] ? fuse_high_reg : fuse_low_reg;

    // ============================================================
    // command window
    always_comb begin
        cmd_next  = cmd_reg;
        win_next  = win_reg;
        busy_next = busy_reg;
        if (busy_reg) begin
            if (nvm_done) begin
                busy_next = 1'b0;
                cmd_next  = 5'h00;
            end
        end else if (accept_cmd) begin
            cmd_next = wr_cmd;
            win_next = fsl_pkg::STORE_WIN;
        end else if (store_go) begin
            if (store_mem && !store_block) begin
                busy_next = 1'b1;
            end else begin
                cmd_next = 5'h00;
            end
            win_next = 3'h0;
        end else if (win_reg != 3'h0) begin
            win_next = win_reg - 3'h1;
            if (win_reg == 3'h1) begin
                cmd_next = 5'h00;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            cmd_reg  <= 5'h00;
            win_reg  <= 3'h0;
            busy_reg <= 1'b0;
        end else begin
            cmd_reg  <= cmd_next;
            win_reg  <= win_next;
            busy_reg <= busy_next;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            sig_rd_reg <= 1'b0;
        end else if (accept_cmd) begin
            sig_rd_reg <= reg_wdata[5];
        end else if (win_reg <= 3'h1) begin
            sig_rd_reg <= 1'b0;
        end
    end

    // ============================================================
    // extra rows, locks and fuses
    always_ff @(posedge clock) begin
        if (rst) begin
            row_ctrl_reg <= fsl_pkg::EXTRA_ROW_RESET;
        end else if (wr_row) begin
            row_ctrl_reg <= reg_wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            lock_reg <= fsl_pkg::LOCK_RESET;
        end else if (wr_erase) begin
            lock_reg <= fsl_pkg::LOCK_RESET;
        end else if (wr_lock) begin
            lock_reg <= lock_ext;
        end else if (store_go && cmd_reg == fsl_pkg::CMD_LOCKSET) begin
            lock_reg <= lock_new;
        end
    end

    // fuses are fixed defaults here; external programming is refused once locked
    always_ff @(posedge clock) begin
        if (rst) begin
            fuse_ext_reg  <= fsl_pkg::FUSE_EXT_RESET;
            fuse_high_reg <= fsl_pkg::FUSE_HIGH_RESET;
            fuse_low_reg  <= fsl_pkg::FUSE_LOW_RESET;
        end else begin
            fuse_ext_reg  <= fuse_ext_reg | fsl_pkg::FUSE_EXT_FIXED;
            fuse_high_reg <= fuse_high_reg;
            fuse_low_reg  <= fuse_low_reg;
        end
    end

    // ============================================================
    // core-facing outputs
    always_ff @(posedge clock) begin
        if (rst) begin
            buf_we        <= 1'b0;
            buf_word      <= 7'h00;
            buf_data      <= 16'h0000;
            page_erase    <= 1'b0;
            page_write    <= 1'b0;
            page_addr     <= 10'h000;
            rww_reenable  <= 1'b0;
        end else begin
            buf_we        <= store_go && (cmd_reg == fsl_pkg::CMD_FILL);
            buf_word      <= ptr[1 +: fsl_pkg::WORD_BITS];
            buf_data      <= reg_pair;
            page_erase    <= store_go && (cmd_reg == fsl_pkg::CMD_ERASE) && !store_block;
            page_write    <= store_go && (cmd_reg == fsl_pkg::CMD_WRITE) && !store_block;
            page_addr     <= ptr[fsl_pkg::PAGE_LSB +: 10];
            rww_reenable  <= store_go && (cmd_reg == fsl_pkg::CMD_RWWRE);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            load_special   <= 1'b0;
            load_data      <= 8'h00;
            load_blocked   <= 1'b0;
            load_sig_space <= 1'b0;
            load_row       <= 2'h0;
            irq_mask       <= 1'b0;
        end else begin
            load_special   <= load_lock;
            load_data      <= ptr[0] ? fuse_sel : lock_reg;
            load_blocked   <= load_instr && !load_lock && !load_sig && rd_blk;
            load_sig_space <= load_sig;
            load_row       <= row_sel;
            irq_mask       <= irq_m;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ext_prog_refused   <= 1'b0;
            ext_verify_refused <= 1'b0;
            ext_lock_refused   <= 1'b0;
            blocked_store_reg  <= 1'b0;
        end else begin
            ext_prog_refused   <= ext_prog_mode && (gen_lock != 2'b11);
            ext_verify_refused <= ext_prog_mode && (gen_lock == 2'b00);
            ext_lock_refused   <= ext_prog_mode && (gen_lock == 2'b00);
            blocked_store_reg  <= store_block ? 1'b1 : (wr_ctrl ? 1'b0 : blocked_store_reg);
        end
    end

    // ============================================================
    // register read
    wire [7:0] ctrl_view = {2'b00, sig_rd_reg, cmd_reg};
    wire [7:0] rd_mux = (reg_addr == fsl_pkg::ADDR_SELFPROG_CTRL) ? ctrl_view :
                        (reg_addr == fsl_pkg::ADDR_EXTRA_ROW)     ? row_ctrl_reg :
                        (reg_addr == fsl_pkg::ADDR_LOCK_BITS)     ? lock_reg :
                        (reg_addr == fsl_pkg::ADDR_FUSE_EXT)      ? fuse_ext_reg :
                        (reg_addr == fsl_pkg::ADDR_FUSE_HIGH)     ? fuse_high_reg :
                        (reg_addr == fsl_pkg::ADDR_FUSE_LOW)      ? fuse_low_reg :
                        (reg_addr == fsl_pkg::ADDR_ACCESS_STAT)   ?
                            {4'h0, blocked_store_reg, busy_reg, app_mode == fsl_pkg::FSL_LOCK_ALL,
                             boot_mode == fsl_pkg::FSL_LOCK_ALL} : 8'h00;

    always_ff @(posedge clock) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
        end
    end

    // ============================================================
    // checks
    a_bad_cmd_ignored: assert property (@(posedge clock) disable iff (rst)
        (wr_ctrl && !cmd_legal && !store_go && win_reg == 3'h0 && !busy_reg) |=> (cmd_reg == 5'h00))
        else $error("illegal command pattern was accepted");
    a_window_expires: assert property (@(posedge clock) disable iff (rst)
        (accept_cmd ##1 (!store_instr && !wr_ctrl) [*4]) |=> (cmd_reg == 5'h00))
        else $error("store enable did not clear after four cycles");
    a_busy_holds: assert property (@(posedge clock) disable iff (rst)
        (busy_reg && !nvm_done) |=> (busy_reg && cmd_reg != 5'h00))
        else $error("store enable dropped during page operation");
    a_fill_word: assert property (@(posedge clock) disable iff (rst)
        (store_go && cmd_reg == fsl_pkg::CMD_FILL) |=> (buf_we && buf_word == $past(ptr[7:1])))
        else $error("buffer fill word wrong");
    a_app_wr_block: assert property (@(posedge clock) disable iff (rst)
        (store_go && store_mem && !in_boot_tgt && app_wblk) |=> (!page_erase && !page_write))
        else $error("store wrote locked application section");
    a_boot_rd_block: assert property (@(posedge clock) disable iff (rst)
        (load_instr && !load_lock && !load_sig && !exec_in_boot && in_boot_tgt && boot_rblk) |=> load_blocked)
        else $error("application load of boot section not blocked");
    a_lock_one_way: assert property (@(posedge clock) disable iff (rst)
        (!wr_erase) |=> ((lock_reg & ~$past(lock_reg)) == 8'h00))
        else $error("lock bit returned to one without erase");
    a_row_default: assert property (@(posedge clock) disable iff (rst)
        (!row_en) |=> (load_row == 2'h0))
        else $error("row select used without extended mode");
    a_ext_refuse: assert property (@(posedge clock) disable iff (rst)
        (ext_prog_mode && gen_lock == 2'b10) |=> (ext_prog_refused && !ext_verify_refused))
        else $error("mode 2 refusal wrong");
    c_fill: cover property (@(posedge clock) disable iff (rst) store_go && cmd_reg == fsl_pkg::CMD_FILL);
    c_page_write: cover property (@(posedge clock) disable iff (rst) page_write);
    c_lock_read: cover property (@(posedge clock) disable iff (rst) load_special);
    c_blocked: cover property (@(posedge clock) disable iff (rst) store_block);
endmodule
`default_nettype wire

//--- src/fsl_lock_decode.sv
// lock-bit pair decoder into protection mode
`timescale 1ns/1ns
`default_nettype none
module fsl_lock_decode (
    input  wire logic [1:0]        lock_pair,
    output fsl_pkg::fsl_lock_t     mode,
    output logic                   block_write,
    output logic                   block_read
);
    // 11 none, 10 write block, 00 all, 01 read only block
    assign mode = (lock_pair == 2'b11) ? fsl_pkg::FSL_LOCK_NONE :
                  (lock_pair == 2'b10) ? fsl_pkg::FSL_LOCK_WRITE :
                  (lock_pair == 2'b00) ? fsl_pkg::FSL_LOCK_ALL : fsl_pkg::FSL_LOCK_READ;
    assign block_write = (mode == fsl_pkg::FSL_LOCK_WRITE) || (mode == fsl_pkg::FSL_LOCK_ALL);
    assign block_read  = (mode == fsl_pkg::FSL_LOCK_ALL) || (mode == fsl_pkg::FSL_LOCK_READ);
endmodule
`default_nettype wire

//--- test/fsl_core_model.sv
// processor core model issuing program-memory store and load instructions
`timescale 1ns/1ns
`default_nettype none
module fsl_core_model (
    input  wire logic   clock,
    output logic        store_instr,
    output logic        load_instr,
    output logic [17:0] ptr,
    output logic [15:0] reg_pair,
    output logic        exec_in_boot,
    output logic        vectors_in_boot
);
    // ============================================================
    // instruction issue
    initial begin
        store_instr = 1'b0;
        load_instr = 1'b0;
        ptr = 18'h0;
        reg_pair = 16'h0;
        exec_in_boot = 1'b0;
        vectors_in_boot = 1'b0;
    end
    // operands inverted after use so stale values never look valid
    task automatic store(input logic [17:0] p, input logic [15:0] d);
        ptr         <= p;
        reg_pair    <= d;
        store_instr <= 1'b1;
        @(posedge clock);
        store_instr <= 1'b0;
        ptr         <= ~p;
        reg_pair    <= ~d;
        #1;
    endtask
    task automatic load(input logic [17:0] p);
        ptr        <= p;
        load_instr <= 1'b1;
        @(posedge clock);
        load_instr <= 1'b0;
        ptr        <= ~p;
        #1;
    endtask
    task automatic where(input logic b, input logic v);
        exec_in_boot    <= b;
        vectors_in_boot <= v;
        @(posedge clock);
        #1;
    endtask
endmodule
`default_nettype wire

//--- test/tb_flash_selfprog_lock_control.sv
// testbench for the self-programming and lock control block
`timescale 1ns/1ns
`default_nettype none
module tb_flash_selfprog_lock_control;
    localparam logic [17:0] BOOT = 18'h3E000;
    logic        clock, rst, reg_wr, reg_rd, nvm_done;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, load_data, rd_v;
    logic        store_instr, load_instr, exec_in_boot, vectors_in_boot;
    logic [17:0] ptr;
    logic [15:0] reg_pair, buf_data;
    logic [6:0]  buf_word;
    logic [9:0]  page_addr;
    logic [1:0]  load_row;
    logic        buf_we, page_erase, page_write, rww_reenable, load_special;
    logic        load_blocked, load_sig_space, irq_mask;
    logic        ext_prog, ext_prog_refused, ext_verify_refused, ext_lock_refused;
    int          n_mismatch, total_checks, cyc;
    logic [7:0]  ra [7] = '{8'h57, 8'h75, 8'h80, 8'h81, 8'h82, 8'h83, 8'h90};
    logic [7:0]  rv [7] = '{8'h00, 8'h0A, 8'hFF, 8'hFE, 8'h99, 8'h62, 8'h00};
    logic [4:0]  cmds [3] = '{fsl_pkg::CMD_ERASE, fsl_pkg::CMD_WRITE, fsl_pkg::CMD_RWWRE};
    logic [2:0]  pulses [3] = '{3'h4, 3'h2, 3'h1};

    fsl_core_model core (.clock(clock), .store_instr(store_instr), .load_instr(load_instr), .ptr(ptr),
        .reg_pair(reg_pair), .exec_in_boot(exec_in_boot), .vectors_in_boot(vectors_in_boot));
    fsl_ctrl dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .store_instr(store_instr), .load_instr(load_instr),
        .ptr(ptr), .reg_pair(reg_pair), .exec_in_boot(exec_in_boot), .vectors_in_boot(vectors_in_boot),
        .boot_start(BOOT), .nvm_done(nvm_done), .ext_prog_mode(ext_prog), .buf_we(buf_we),
        .buf_word(buf_word), .buf_data(buf_data), .page_erase(page_erase), .page_write(page_write),
        .page_addr(page_addr), .rww_reenable(rww_reenable), .load_special(load_special),
        .load_data(load_data), .load_blocked(load_blocked), .load_sig_space(load_sig_space),
        .load_row(load_row), .irq_mask(irq_mask), .ext_prog_refused(ext_prog_refused),
        .ext_verify_refused(ext_verify_refused), .ext_lock_refused(ext_lock_refused));

    // ============================================================
    // clock, timeout and shared tasks
    initial clock = 1'b0;
    always #2 clock = ~clock;
    always @(posedge clock) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            close_out();
        end
    end
    task automatic close_out();
        if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr    <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd   <= 1'b0;
        #1;
        rd_v = reg_rdata;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic flash_done();
        nvm_done <= 1'b1;
        @(posedge clock);
        nvm_done <= 1'b0;
        #1;
    endtask
    task automatic lockset(input logic [7:0] v);
        wr(8'h57, {3'h0, fsl_pkg::CMD_LOCKSET});
        core.store(18'h0, {8'h55, v});
    endtask

    // ============================================================
    // test sequence
    initial begin
        {reg_wr, reg_rd, nvm_done, ext_prog, reg_addr, reg_wdata} = '0;
        rst = 1'b1;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        #1;
        foreach (ra[i]) begin
            rd(ra[i]);
            chk(rd_v, rv[i]);
        end
        wr(8'h82, 8'h00);
        rd(8'h82);
        chk(rd_v, 8'h99);
        wr(8'h57, 8'h01);
        idle(3);
        core.store(18'h00105, 16'hBEEF);
        chk({buf_we, buf_word, buf_data}, {1'b1, 7'h02, 16'hBEEF});
        rd(8'h57);
        chk(rd_v, 8'h00);
        wr(8'h57, 8'h01);
        idle(4);
        core.store(18'h00104, 16'h1111);
        chk(buf_we, 1'b0);
        rd(8'h57);
        chk(rd_v, 8'h00);
        wr(8'h57, 8'h07);
        core.store(18'h00104, 16'h2222);
        chk({buf_we, page_erase, page_write}, 3'h0);
        for (int k = 0; k < 3; k++) begin
            wr(8'h57, {3'h0, cmds[k]});
            core.store(18'h2A3FE, 16'h1234);
            chk({page_erase, page_write, rww_reenable}, pulses[k]);
            if (k < 2) begin
                chk(page_addr, 10'h2A3);
                idle(8);
                rd(8'h57);
                chk(rd_v[0], 1'b1);
                flash_done();
                rd(8'h57);
                chk(rd_v, 8'h00);
            end
        end
        for (int k = 0; k < 2; k++) begin
            wr(8'h57, {3'h0, fsl_pkg::CMD_LOCKSET});
            idle(2);
            core.load({17'h0, k[0]});
            chk({load_special, load_data}, k ? 9'h199 : 9'h1FF);
        end
        lockset(8'hF3); // app locks only, general pair untouched
        rd(8'h80);
        chk(rd_v, 8'hF3);
        lockset(8'hFF);
        rd(8'h80);
        chk(rd_v, 8'hF3);
        wr(8'h57, {3'h0, fsl_pkg::CMD_ERASE});
        core.store(18'h01000, 16'h0);
        chk(page_erase, 1'b0);
        rd(8'h84);
        chk(rd_v, 8'h0A);
        wr(8'h57, {3'h0, fsl_pkg::CMD_ERASE});
        core.store(BOOT, 16'h0);
        chk(page_erase, 1'b1);
        flash_done();
        core.where(1'b1, 1'b1);
        core.load(18'h00100);
        chk(load_blocked, 1'b1);
        core.where(1'b0, 1'b1);
        chk(irq_mask, 1'b1);
        core.where(1'b0, 1'b0);
        wr(8'h85, fsl_pkg::CHIP_ERASE_KEY);
        rd(8'h80);
        chk(rd_v, 8'hFF);
        lockset(8'hE7);
        wr(8'h57, {3'h0, fsl_pkg::CMD_ERASE});
        core.store(BOOT, 16'h0);
        chk(page_erase, 1'b0);
        wr(8'h57, {3'h0, fsl_pkg::CMD_ERASE});
        core.store(18'h01000, 16'h0);
        chk(page_erase, 1'b1);
        flash_done();
        core.load(BOOT);
        chk(load_blocked, 1'b0);
        core.where(1'b1, 1'b0);
        core.load(18'h00100);
        chk(load_blocked, 1'b1);
        for (int r = 0; r < 4; r++) begin
            wr(8'h75, {2'h1, r[1:0], 4'hA});
            wr(8'h57, 8'h21);
            core.load(18'h0);
            chk({load_sig_space, load_row}, {1'b1, r[1:0]});
        end
        wr(8'h75, 8'h2A);
        rd(8'h75);
        chk(rd_v, 8'h2A);
        wr(8'h57, 8'h21);
        core.load(18'h0);
        chk({load_sig_space, load_row}, 3'h4);
        ext_prog <= 1'b1;
        wr(8'h80, 8'hFE); // boot locks already set before general locks
        rd(8'h80);
        chk(rd_v, 8'hE6);
        chk({ext_prog_refused, ext_verify_refused, ext_lock_refused}, 3'h4);
        wr(8'h80, 8'hFC);
        wr(8'h80, 8'h00);
        rd(8'h80);
        chk(rd_v, 8'hE4);
        chk({ext_prog_refused, ext_verify_refused, ext_lock_refused}, 3'h7);
        ext_prog <= 1'b0;
        wr(8'h85, fsl_pkg::CHIP_ERASE_KEY);
        rd(8'h80);
        chk(rd_v, 8'hFF);
        chk({ext_prog_refused, ext_verify_refused, ext_lock_refused}, 3'h0);
        close_out();
    end
endmodule
`default_nettype wire
